// >>> watchdog_reset_flag_defines.svh
// Register offsets, field positions and timing counts of the watchdog block
`ifndef WATCHDOG_RESET_FLAG_DEFINES_SVH
`define WATCHDOG_RESET_FLAG_DEFINES_SVH
`define WATCHDOG_RESET_FLAG_CAUSE_DATA_ADDR 8'h54
`define WATCHDOG_RESET_FLAG_CAUSE_IO_ADDR 6'h34
`define WATCHDOG_RESET_FLAG_IO_OFFSET 8'h20
`define WATCHDOG_RESET_FLAG_EXT_BASE 8'h60
`define WATCHDOG_RESET_FLAG_CTRL_DATA_ADDR 8'h60
`define WATCHDOG_RESET_FLAG_CAUSE_RESET 8'h00
`define WATCHDOG_RESET_FLAG_CTRL_RESET 8'h00
`define WATCHDOG_RESET_FLAG_BIT_DBG 4
`define WATCHDOG_RESET_FLAG_BIT_WDOG 3
`define WATCHDOG_RESET_FLAG_BIT_BOR 2
`define WATCHDOG_RESET_FLAG_BIT_EXT 1
`define WATCHDOG_RESET_FLAG_BIT_POR 0
`define WATCHDOG_RESET_FLAG_BIT_IRQF 7
`define WATCHDOG_RESET_FLAG_BIT_IRQE 6
`define WATCHDOG_RESET_FLAG_BIT_PS3 5
`define WATCHDOG_RESET_FLAG_BIT_CHGE 4
`define WATCHDOG_RESET_FLAG_BIT_RSTE 3
`define WATCHDOG_RESET_FLAG_CHG_CYCLES 3'd4
`define WATCHDOG_RESET_FLAG_MAX_CODE 4'h9
`define WATCHDOG_RESET_FLAG_BASE_TIMEOUT 2048
`endif

// >>> watchdog_reset_flag_pkg.sv
// Types shared by the watchdog block
package watchdog_reset_flag_pkg;
    typedef enum logic [1:0] {
        WATCHDOG_RESET_FLAG_STOPPED = 2'b00,
        WATCHDOG_RESET_FLAG_IRQ = 2'b01,
        WATCHDOG_RESET_FLAG_RESET = 2'b10,
        WATCHDOG_RESET_FLAG_IRQ_RESET = 2'b11
    } watchdog_reset_flag_mode_t;
endpackage

// >>> watchdog_reset_flag_watchdog.sv
// Watchdog timer control with reset-cause flag register
`timescale 1ns/1ns
`include "watchdog_reset_flag_defines.svh"

// Overview of operation
// R1 - Reset-cause register sits at data 0x54, I/O 0x34, resets to zero
// R2 - I/O accesses address registers below 0x60 at data offset minus 0x20
// R3 - Registers from 0x60 upward answer only data-space accesses
// R4 - Debug-port reset flag sets on debug reset, clears on power-on or zero write
// R5 - Watchdog reset flag sets on watchdog reset, clears on power-on or zero write
// R6 - Brown-out flag sets on brown-out reset, clears on power-on or zero write
// R7 - External flag sets on pin reset, clears on power-on or zero write
// R8 - Power-on flag sets on power-on, clears only by software zero write
// R9 - Control register at 0x60, resets zero, fixed bit layout
// R10 - Interrupt flag sets on timeout while interrupt action configured
// R11 - Interrupt flag clears on vector execution or software one write
// R12 - Interrupt requested only with global and watchdog enables both set
// R13 - Vector in combined mode clears enable and flag, leaving reset mode
// R14 - Combined mode second timeout before vector applies system reset
// R15 - Software re-enables interrupt after each combined-mode vector, outside service routine
// R16 - Unprogrammed fuse: reset and interrupt enables choose the mode
// R17 - Programmed fuse forces system reset mode regardless of enables
// R18 - Change-enable self-clears four clocks after being written one
// R19 - Reset-enable clear or prescaler change only while change-enable set
// R20 - Watchdog reset flag forces reset enable to one
// R21 - Prescale code 0 to 9 selects 2048 to 1048576 cycles, rest reserved
// R22 - Change sequence: write enables together, then new values in four clocks
// R23 - Counter counts slow oscillator ticks, restarts on restart instruction
// R24 - Reset-mode timeout emits a one-clock system reset pulse
// R25 - Programmed fuse holds reset enable one and interrupt enable zero
// R26 - Unused cause bits 7 to 5 read zero and ignore writes
module watchdog_reset_flag_watchdog
    import watchdog_reset_flag_pkg::*;
#(
    parameter int CNT_WIDTH = 21
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // CPU register access
    input wire logic [7:0] regAddr,
    input wire logic ioSpace,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata,
    // Reset sources and strap
    input wire logic powerOnReset,
    input wire logic externalReset,
    input wire logic brownoutReset,
    input wire logic debugReset,
    input wire logic failsafeAlwaysOnFuse,
    // CPU events
    input wire logic watchdogRestart,
    input wire logic irqVectorTaken,
    input wire logic globalIrqEnable,
    // Slow oscillator tick, one clock wide
    input wire logic slowTick,
    // Results
    output logic watchdogIrq,
    output logic watchdogSysReset,
    output logic [1:0] watchdogMode
);

    // Register state
    logic [4:0] cause_q;
    logic irqFlag_q;
    logic irqEnable_q;
    logic [3:0] prescale_q;
    logic changeEnable_q;
    logic resetEnable_q;
    logic [2:0] changeCnt_q;
    logic [CNT_WIDTH-1:0] count_q;
    // Decode and control terms
    logic [7:0] dataAddr;
    logic hitCause;
    logic hitCtrl;
    logic wrCause;
    logic wrCtrl;
    logic chgArm;
    logic chgClose;
    logic fuseOn;
    logic effRstEn;
    logic effIrqEn;
    watchdog_reset_flag_mode_t mode;
    logic timeout;
    logic [3:0] codeUsed;
    logic [CNT_WIDTH-1:0] limit;
    logic [7:0] ctrlView;
    logic [4:0] causeSet;
    logic [7:0] readMux;

    // Address decode; I/O space reaches only the low 64 locations
    always_comb begin
        // Data-space accesses use the address as given
        dataAddr = regAddr;
        hitCause = 1'b0;
        hitCtrl = 1'b0;
        if (ioSpace) begin
            dataAddr = {2'b00, regAddr[5:0]} + `WATCHDOG_RESET_FLAG_IO_OFFSET; // R2
        end
        if (dataAddr == `WATCHDOG_RESET_FLAG_CAUSE_DATA_ADDR) begin
            hitCause = 1'b1; // R1
        end else if (!ioSpace && dataAddr == `WATCHDOG_RESET_FLAG_CTRL_DATA_ADDR) begin
            // Extended space is out of reach of the short I/O form
            hitCtrl = 1'b1; // R3
        end
    end

    // Write strobes per register
    assign wrCause = regWrite && hitCause;
    assign wrCtrl = regWrite && hitCtrl;

    // Window opens only on a write with change-enable and reset-enable together
    assign chgArm = wrCtrl && regWdata[`WATCHDOG_RESET_FLAG_BIT_CHGE] && regWdata[`WATCHDOG_RESET_FLAG_BIT_RSTE]; // R22
    // Any other control write while open uses the window up
    assign chgClose = wrCtrl && changeEnable_q && !chgArm; // R22

    // Fuse and mode selection; a programmed fuse reads as zero
    assign fuseOn = !failsafeAlwaysOnFuse; // R17
    assign effRstEn = fuseOn || resetEnable_q || cause_q[`WATCHDOG_RESET_FLAG_BIT_WDOG]; // R20 R25
    assign effIrqEn = !fuseOn && irqEnable_q; // R25
    assign mode = watchdog_reset_flag_mode_t'({effRstEn, effIrqEn}); // R16 R17

    // Reserved codes clamp to the longest period so the timer never stalls
    always_comb begin
        if (prescale_q > `WATCHDOG_RESET_FLAG_MAX_CODE) begin
            codeUsed = `WATCHDOG_RESET_FLAG_MAX_CODE; // R21
        end else begin
            codeUsed = prescale_q; // R21
        end
    end

    // Base period shifted up once per code step
    assign limit = CNT_WIDTH'(`WATCHDOG_RESET_FLAG_BASE_TIMEOUT) << codeUsed; // R21

    // Timeout on the tick that would take the count to the limit
    assign timeout = slowTick && (mode != WATCHDOG_RESET_FLAG_STOPPED) && (count_q >= limit - 1'b1);

    // Slow-tick counter; a shorter code without restart may time out at once
    always_ff @(posedge clk) begin
        // Restart and timeout both begin a fresh period
        if (rst || watchdogRestart || timeout) begin
            count_q <= '0; // R23
        end else if (slowTick && mode != WATCHDOG_RESET_FLAG_STOPPED) begin
            count_q <= count_q + 1'b1; // R23
        end
    end

    // Hardware set events, one per cause bit; power-on is handled apart
    always_comb begin
        causeSet = 5'b0_0000;
        causeSet[`WATCHDOG_RESET_FLAG_BIT_DBG] = debugReset; // R4
        causeSet[`WATCHDOG_RESET_FLAG_BIT_WDOG] = watchdogSysReset; // R5
        causeSet[`WATCHDOG_RESET_FLAG_BIT_BOR] = brownoutReset; // R6
        causeSet[`WATCHDOG_RESET_FLAG_BIT_EXT] = externalReset; // R7
    end

    // Reset-cause flags; a set beats a same-cycle software clear
    always_ff @(posedge clk) begin
        if (rst) begin
            cause_q <= 5'(`WATCHDOG_RESET_FLAG_CAUSE_RESET);
        end else if (powerOnReset) begin
            // Power-on marks itself and wipes every other cause
            cause_q <= 5'b0_0001; // R8 R4 R5 R6 R7
        end else begin
            // Writing one never sets a flag, so the write is an AND
            cause_q <= (wrCause ? regWdata[4:0] & cause_q : cause_q) | causeSet; // R8 R26
        end
    end

    // Change-enable flag and its four-clock window counter
    always_ff @(posedge clk) begin
        if (rst) begin
            changeEnable_q <= 1'b0;
            changeCnt_q <= 3'd0;
        end else if (chgArm) begin
            changeEnable_q <= 1'b1; // R22
            changeCnt_q <= `WATCHDOG_RESET_FLAG_CHG_CYCLES;
        end else if (chgClose) begin
            changeEnable_q <= 1'b0; // R22
            changeCnt_q <= 3'd0;
        end else if (changeCnt_q != 3'd0) begin
            // Drops on the fourth edge after the opening write
            changeCnt_q <= changeCnt_q - 3'd1;
            changeEnable_q <= (changeCnt_q != 3'd1); // R18
        end
    end

    // Reset enable; only a write inside the window may clear it
    always_ff @(posedge clk) begin
        if (rst) begin
            resetEnable_q <= 1'b0;
        end else if (wrCtrl) begin
            // Setting needs no window
            if (regWdata[`WATCHDOG_RESET_FLAG_BIT_RSTE]) begin
                resetEnable_q <= 1'b1;
            end else if (changeEnable_q && !cause_q[`WATCHDOG_RESET_FLAG_BIT_WDOG]) begin
                // Watchdog reset flag must be cleared first
                resetEnable_q <= 1'b0; // R19 R20
            end
        end
    end

    // Prescaler; outside the window writes leave it alone
    always_ff @(posedge clk) begin
        if (rst) begin
            prescale_q <= 4'h0;
        end else if (wrCtrl && changeEnable_q) begin
            prescale_q <= {regWdata[`WATCHDOG_RESET_FLAG_BIT_PS3], regWdata[2:0]}; // R19
        end
    end

    // Interrupt enable; the vector in combined mode drops back to reset-only
    always_ff @(posedge clk) begin
        if (rst) begin
            irqEnable_q <= 1'b0;
        end else if (irqVectorTaken && mode == WATCHDOG_RESET_FLAG_IRQ_RESET) begin
            // Software must set it again to stay in combined mode
            irqEnable_q <= 1'b0; // R13
        end else if (wrCtrl) begin
            irqEnable_q <= regWdata[`WATCHDOG_RESET_FLAG_BIT_IRQE];
        end
    end

    // Interrupt flag; a timeout set wins over a vector or a written one
    always_ff @(posedge clk) begin
        if (rst) begin
            irqFlag_q <= 1'b0;
        end else if (timeout && effIrqEn && !(mode == WATCHDOG_RESET_FLAG_IRQ_RESET && irqFlag_q)) begin
            irqFlag_q <= 1'b1; // R10
        end else if (irqVectorTaken) begin
            irqFlag_q <= 1'b0; // R11 R13
        end else if (wrCtrl && regWdata[`WATCHDOG_RESET_FLAG_BIT_IRQF]) begin
            irqFlag_q <= 1'b0; // R11
        end
    end

    // Reset pulse: reset-only mode, or combined mode with flag still pending
    always_ff @(posedge clk) begin
        if (rst) begin
            watchdogSysReset <= 1'b0;
        end else begin
            // Counter restarts on timeout, so the pulse lasts one clock
            watchdogSysReset <= timeout && ((mode == WATCHDOG_RESET_FLAG_RESET)
                || (mode == WATCHDOG_RESET_FLAG_IRQ_RESET && irqFlag_q)); // R24 R14
        end
    end

    // Interrupt request gated by both enables
    always_ff @(posedge clk) begin
        if (rst) begin
            watchdogIrq <= 1'b0;
        end else begin
            // Registered, so the request trails the flag by one clock
            watchdogIrq <= irqFlag_q && effIrqEn && globalIrqEnable; // R12
        end
    end

    // Mode as seen by the rest of the chip
    always_ff @(posedge clk) begin
        if (rst) begin
            watchdogMode <= 2'b00;
        end else begin
            // Effective mode, so a programmed fuse shows as reset-only
            watchdogMode <= mode;
        end
    end

    // Control view shows the effective enables, not the stored ones
    always_comb begin
        ctrlView = 8'h00;
        ctrlView[`WATCHDOG_RESET_FLAG_BIT_IRQF] = irqFlag_q; // R9
        ctrlView[`WATCHDOG_RESET_FLAG_BIT_IRQE] = effIrqEn;
        ctrlView[`WATCHDOG_RESET_FLAG_BIT_PS3] = prescale_q[3];
        ctrlView[`WATCHDOG_RESET_FLAG_BIT_CHGE] = changeEnable_q;
        ctrlView[`WATCHDOG_RESET_FLAG_BIT_RSTE] = effRstEn;
        ctrlView[2:0] = prescale_q[2:0];
    end

    // Read multiplexer; unmapped addresses read zero
    always_comb begin
        if (hitCause) begin
            readMux = {3'b000, cause_q}; // R26
        end else if (hitCtrl) begin
            readMux = ctrlView; // R9
        end else begin
            readMux = 8'h00;
        end
    end

    // Read data register; zero between reads so stale data never lingers
    always_ff @(posedge clk) begin
        if (rst) begin
            regRdata <= `WATCHDOG_RESET_FLAG_CTRL_RESET;
        end else if (regRead) begin
            regRdata <= readMux;
        end else begin
            regRdata <= 8'h00;
        end
    end

endmodule

// >>> watchdog_reset_flag_watchdog_assertions.sv
// Port checker for the watchdog block
`timescale 1ns/1ns
module watchdog_reset_flag_watchdog_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register side
    input wire logic [7:0] regAddr,
    input wire logic ioSpace,
    input wire logic regRead,
    input wire logic [7:0] regRdata,
    // Events and results
    input wire logic failsafeAlwaysOnFuse,
    input wire logic irqVectorTaken,
    input wire logic globalIrqEnable,
    input wire logic watchdogIrq,
    input wire logic watchdogSysReset,
    input wire logic [1:0] watchdogMode
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Three samples give the mode register time to follow the fuse
    sequence s_fuse_on;
        !failsafeAlwaysOnFuse [*3];
    endsequence
    sequence s_cause_rd;
        regRead && (ioSpace ? regAddr[5:0] == 6'h34 : regAddr == 8'h54);
    endsequence
    property p_rd_idle; !regRead |=> regRdata == 8'h00; endproperty
    property p_cause_hi; s_cause_rd |=> regRdata[7:5] == 3'b000; endproperty
    property p_io_other; regRead && ioSpace && regAddr[5:0] != 6'h34 |=> !regRdata; endproperty
    property p_fuse; s_fuse_on |-> watchdogMode == 2'b10; endproperty
    property p_rst_pulse; watchdogSysReset |=> !watchdogSysReset; endproperty
    property p_rst_mode; watchdogSysReset |-> $past(watchdogMode[1]); endproperty
    property p_irq_gate; watchdogIrq |-> $past(globalIrqEnable); endproperty
    property p_irq_mode; $rose(watchdogIrq) |-> $past(watchdogMode[0]); endproperty
    property p_vector;
        irqVectorTaken && watchdogMode == 2'b11 |-> ##2 watchdogMode == 2'b10 && !watchdogIrq;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
    a_cause_hi: assert property (p_cause_hi) else $error("cause top bits set");
    a_io_other: assert property (p_io_other) else $error("io read hit");
    a_fuse: assert property (p_fuse) else $error("fuse mode wrong");
    a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse long");
    a_rst_mode: assert property (p_rst_mode) else $error("reset w/o enable");
    a_irq_gate: assert property (p_irq_gate) else $error("irq w/o global");
    a_irq_mode: assert property (p_irq_mode) else $error("irq w/o enable");
    a_vector: assert property (p_vector) else $error("vector no clear");
endmodule

bind watchdog_reset_flag_watchdog watchdog_reset_flag_watchdog_chk i_watchdog_reset_flag_watchdog_chk (.clk(clk), .rst(rst),
    .regAddr(regAddr), .ioSpace(ioSpace), .regRead(regRead), .regRdata(regRdata),
    .failsafeAlwaysOnFuse(failsafeAlwaysOnFuse), .irqVectorTaken(irqVectorTaken),
    .globalIrqEnable(globalIrqEnable), .watchdogIrq(watchdogIrq),
    .watchdogSysReset(watchdogSysReset), .watchdogMode(watchdogMode));

// >>> testbench.sv
// Self-checking testbench for the watchdog block
`timescale 1ns/1ns
module testbench;
    logic clk = 0, rst = 1, ioSpace = 0, regWrite = 0, regRead = 0, fuse = 1;
    logic gie = 0, tick = 0, rdPend = 0, irq, sysRst;
    logic [6:0] ev = 0;
    logic [7:0] addr = 0, wdata = 0, rdata;
    logic [1:0] mode;
    logic [7:0] expQ[$];
    logic [31:0] seed = 32'h0510;
    int fail_count = 0, compares = 0;
    // Event bits: 0 por, 1 ext, 2 bor, 4 debug, 5 restart, 6 vector
    watchdog_reset_flag_watchdog i_watchdog_reset_flag_watchdog (.clk(clk), .rst(rst), .regAddr(addr), .ioSpace(ioSpace),
        .regWrite(regWrite), .regRead(regRead), .regWdata(wdata), .regRdata(rdata),
        .powerOnReset(ev[0]), .externalReset(ev[1]), .brownoutReset(ev[2]),
        .debugReset(ev[4]), .failsafeAlwaysOnFuse(fuse), .watchdogRestart(ev[5]),
        .irqVectorTaken(ev[6]), .globalIrqEnable(gie), .slowTick(tick),
        .watchdogIrq(irq), .watchdogSysReset(sysRst), .watchdogMode(mode));
    always #2 clk = ~clk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim;
        $display("Counts: %0d compares, %0d mismatches", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // One register access; a read notes its expected answer
    task automatic acc(input logic w, input logic io, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk) {regWrite, regRead, ioSpace, addr, wdata} <= {w, !w, io, a, d};
        if (!w) expQ.push_back(d);
        @(negedge clk) {regWrite, regRead} <= 2'b00;
    endtask
    task automatic pulse(input logic [6:0] v);
        @(negedge clk) ev <= v;
        @(negedge clk) ev <= 7'h00;
    endtask
    // Bounded wait so a dead timer cannot hang the run
    task automatic waitFor(input logic rstSel, input int lim);
        int cyc;
        cyc = 0;
        while ((rstSel ? sysRst : irq) !== 1'b1 && cyc < lim) begin
            @(negedge clk);
            cyc++;
        end
        check({7'h00, (rstSel ? sysRst : irq)}, 8'h01);
    endtask
    // Read answers arrive one cycle after the strobe
    always @(posedge clk) begin
        if (rdPend) check(rdata, expQ.pop_front());
        rdPend <= regRead;
    end
    initial begin
        #200000;
        fail_count++;
        end_sim();
    end
    initial begin
        repeat (20) @(posedge clk);
        @(negedge clk) rst <= 0;
        acc(0, 0, 8'h54, 8'h00);
        acc(0, 1, 8'h34, 8'h00);
        acc(0, 0, 8'h60, 8'h00);
        for (int i = 1; i < 5; i++) if (i != 3) pulse(7'h01 << i);
        acc(0, 0, 8'h54, 8'h16);
        pulse(7'h01);
        acc(0, 1, 8'h34, 8'h01);
        seed = xs(seed);
        acc(1, 0, 8'h54, seed[7:0]);
        acc(0, 0, 8'h54, 8'h01 & seed[7:0]);
        acc(1, 1, 8'h34, 8'h00);
        acc(1, 0, 8'h54, 8'hFF);
        acc(0, 0, 8'h54, 8'h00);
        $display("test flags done");
        acc(1, 0, 8'h60, 8'h08);
        acc(1, 0, 8'h60, 8'h00);
        acc(0, 0, 8'h60, 8'h08);
        acc(1, 0, 8'h60, 8'h18);
        acc(1, 0, 8'h60, 8'h05);
        acc(0, 0, 8'h60, 8'h05);
        acc(1, 0, 8'h60, 8'h1D);
        acc(0, 0, 8'h60, 8'h1D);
        repeat (4) @(negedge clk);
        acc(0, 0, 8'h60, 8'h0D);
        acc(1, 0, 8'h60, 8'h02);
        acc(0, 0, 8'h60, 8'h0D);
        acc(1, 0, 8'h60, 8'h1D);
        acc(1, 0, 8'h60, 8'h00);
        acc(0, 0, 8'h60, 8'h00);
        $display("test change done");
        fuse <= 0;
        repeat (3) @(negedge clk);
        check({6'h00, mode}, 8'h02);
        acc(1, 0, 8'h60, 8'h18);
        acc(1, 0, 8'h60, 8'h00);
        acc(0, 0, 8'h60, 8'h08);
        fuse <= 1;
        acc(1, 0, 8'h60, 8'h18);
        acc(1, 0, 8'h60, 8'h40);
        tick <= 1;
        pulse(7'h20);
        repeat (2038) @(negedge clk);
        acc(0, 0, 8'h60, 8'h40);
        repeat (60) @(negedge clk);
        check({7'h00, irq}, 8'h00);
        gie <= 1;
        repeat (2) @(negedge clk);
        check({7'h00, irq}, 8'h01);
        acc(0, 0, 8'h60, 8'hC0);
        acc(1, 0, 8'h60, 8'hC0);
        acc(0, 0, 8'h60, 8'h40);
        $display("test irq done");
        for (int v = 0; v < 2; v++) begin
            acc(1, 0, 8'h60, 8'h48);
            pulse(7'h20);
            waitFor(0, 2100);
            if (v == 0) pulse(7'h40);
            if (v == 0) acc(0, 0, 8'h60, 8'h08);
            waitFor(1, 4200);
            check({7'h00, sysRst}, 8'h01);
            acc(0, 0, 8'h54, 8'h08);
            acc(1, 0, 8'h60, 8'h18);
            acc(1, 0, 8'h60, 8'h80);
            acc(0, 0, 8'h60, 8'h08);
            acc(1, 0, 8'h54, 8'h00);
            acc(1, 0, 8'h60, 8'h18);
            acc(1, 0, 8'h60, 8'h80);
            acc(0, 0, 8'h60, 8'h00);
        end
        $display("test combined done");
        end_sim();
    end
endmodule
